// [hdl/pdm_regs.svh]
// Register map, field positions, reset values and timing counts
// for the power-down controller. Included by its bare name.
`ifndef PDM_REGS_SVH
`define PDM_REGS_SVH

// Byte offsets on the register bus
`define PDM_SYSCTL_OFS   8'h00
`define PDM_MSTOP_OFS    8'h04
`define PDM_STATUS_OFS   8'h08

// system_control_reg fields
`define PDM_SOFT_STANDBY_BIT 7
`define PDM_EDGE_SEL_BIT     2
`define PDM_RAM_EN_BIT       0
`define PDM_SYSCTL_RST   8'h01

// module_stop_ctrl_reg fields
`define PDM_CLKOUT_DIS_BIT 7
`define PDM_MST_TMR_BIT  5
`define PDM_MST_SC0_BIT  4
`define PDM_MST_SC1_BIT  3
`define PDM_MST_ADC_BIT  0
`define PDM_MSTOP_RST    8'h00

// Status fields
`define PDM_ST_OSC_BIT   7
`define PDM_ST_HWS_BIT   6

// Read value of a stopped module's registers
`define PDM_STOPPED_RD   8'hFF

// Reset exception handling time in ns, and its cycle count at 200 MHz
`define PDM_CLK_MHZ      200
`define PDM_RSTEXC_NS    40
`define PDM_RSTEXC_CYC   ((`PDM_RSTEXC_NS * `PDM_CLK_MHZ + 999) / 1000)

`endif

// [hdl/pdm_pkg.sv]
// Types shared by the power-down controller modules.
// Assumes the constants header is compiled alongside.
package pdm_pkg;

  typedef enum logic [2:0] {
    PDM_RESET,
    PDM_RSTEXC,
    PDM_RUN,
    PDM_SLEEP,
    PDM_SWSTBY
  } pdm_state_t;

  typedef logic [7:0] pdm_byte_t;

endpackage

// [hdl/pdm_gate_if.sv]
// Carrier between the controller and one module-stop gate.
// Assumes both ends run on the core clock.
`timescale 1ns/1ps
interface pdm_gate_if;
  import pdm_pkg::*;

  logic      stop;
  pdm_byte_t rd_raw;
  logic      wr_req;
  pdm_byte_t rd_out;
  logic      wr_out;
  logic      mod_rst_n;
  logic      pin_func;

  modport ctrl
  (
    output stop,
    output rd_raw,
    output wr_req,
    input  rd_out,
    input  wr_out,
    input  mod_rst_n,
    input  pin_func
  );

  modport gate
  (
    input  stop,
    input  rd_raw,
    input  wr_req,
    output rd_out,
    output wr_out,
    output mod_rst_n,
    output pin_func
  );
endinterface

// [hdl/pdm_mod_gate.sv]
// Module-stop gate for one supporting module.
// Assumes a synchronised active-low reset on the core clock.
`timescale 1ns/1ps
`include "pdm_regs.svh"
module pdm_mod_gate
(
  input  wire logic i_core_clk,
  input  wire logic i_rst_n,
  pdm_gate_if.gate  g
);
  import pdm_pkg::*;

  logic rst_n_r;
  logic rst_n_nxt;
  logic pin_r;
  logic pin_nxt;

  // Module reset and pin ownership follow the stop bit
  always_comb
  begin
    rst_n_nxt = ~g.stop;
    pin_nxt   = ~g.stop;
  end

  always_ff @(posedge i_core_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      rst_n_r <= 1'b0;
      pin_r   <= 1'b0;
    end
    else
    begin
      rst_n_r <= rst_n_nxt;
      pin_r   <= pin_nxt;
    end
  end

  // Register access is blocked while stopped
  assign g.rd_out    = g.stop ? `PDM_STOPPED_RD : g.rd_raw;
  assign g.wr_out    = g.wr_req & ~g.stop;
  assign g.mod_rst_n = rst_n_r;
  assign g.pin_func  = pin_r;
endmodule

// [hdl/pdm_top.sv]
// Power-down mode controller: software standby, hardware standby,
// module stop and system clock output control, AHB-Lite registers.
// Assumes standby, reset, mode and interrupt pins are asynchronous,
// and the CPU sleep request is a one-cycle pulse on the core clock.
`timescale 1ns/1ps
`include "pdm_regs.svh"

// Contract
// - edge select 0 falling, 1 rising
// - sleep with standby bit enters software standby
// - rising selection exits standby on rising edge
// - ports hold state in software standby
// - standby pin low enters hardware standby
// - hardware standby halts and resets all but RAM
// - ports high impedance in hardware standby
// - standby rise restarts oscillator during reset
// - reset rise runs reset exception, then execution
// - stop bit halts module next bus cycle
// - stopped module reads FF, ignores writes
// - stopping initialises registers and pending interrupts
// - stopped module pins revert to general I/O
// - cleared stop resumes from initialised registers
// - clock out disable stops and floats pin
// - clock pin state follows operating state
module pdm_top
(
  input  wire logic             i_core_clk,
  input  wire logic             i_arst_n,
  input  wire logic             i_standby_n_pin,
  input  wire logic             i_reset_n_pin,
  input  wire logic             i_nmi_pin,
  input  wire logic [2:0]       i_mode_select_pins,
  input  wire logic             i_sleep_req,
  input  wire logic             i_irq,
  input  wire logic [31:0]      i_mod_rdata,
  input  wire logic [3:0]       i_mod_wr,
  input  wire logic             i_hsel,
  input  wire logic [31:0]      i_haddr,
  input  wire logic [1:0]       i_htrans,
  input  wire logic             i_hwrite,
  input  wire logic [2:0]       i_hsize,
  input  wire logic [31:0]      i_hwdata,
  input  wire logic             i_hready,
  output logic                  o_hreadyout,
  output logic                  o_hresp,
  output logic [31:0]           o_hrdata,
  output pdm_pkg::pdm_state_t   o_state,
  output logic                  o_hw_standby,
  output logic                  o_osc_enable,
  output logic                  o_cpu_halt,
  output logic                  o_periph_halt,
  output logic                  o_reset_exc,
  output logic                  o_nmi_event,
  output logic                  o_port_hold,
  output logic                  o_port_hiz,
  output logic                  o_ram_enable,
  output logic [2:0]            o_mode,
  output logic                  o_clkout_oe,
  output logic                  o_clkout_high,
  output logic [31:0]           o_mod_rdata,
  output logic [3:0]            o_mod_wr,
  output logic [3:0]            o_mod_rst_n,
  output logic [3:0]            o_mod_halt,
  output logic [3:0]            o_mod_pin_func
);
  import pdm_pkg::*;

  localparam logic [2:0] RSTEXC_LAST = 3'(`PDM_RSTEXC_CYC - 1);

  // ----------------------------------------------------------------
  // Resets
  // ----------------------------------------------------------------
  // Standby pin joins the reset tree so it acts without the clock
  logic pin_arst_n;
  logic rs1_r;
  logic rst_n;
  logic hws_r;
  logic osc_r;

  assign pin_arst_n = i_arst_n & i_standby_n_pin;

  // Release goes through two flops; assertion is immediate
  always_ff @(posedge i_core_clk or negedge pin_arst_n)
  begin
    if (!pin_arst_n)
    begin
      rs1_r <= 1'b0;
      rst_n <= 1'b0;
      hws_r <= 1'b1;
      osc_r <= 1'b0;
    end
    else
    begin
      rs1_r <= 1'b1;
      rst_n <= rs1_r;
      hws_r <= ~rs1_r;
      osc_r <= 1'b1; // runs before reset pin rises
    end
  end

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  logic [4:0] pin_s1_r;
  logic [4:0] pin_s2_r;
  logic       nmi_d_r;

  always_ff @(posedge i_core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pin_s1_r <= 5'h00;
      pin_s2_r <= 5'h00;
      nmi_d_r  <= 1'b0;
    end
    else
    begin
      pin_s1_r <= {i_mode_select_pins, i_nmi_pin, i_reset_n_pin};
      pin_s2_r <= pin_s1_r;
      nmi_d_r  <= pin_s2_r[1];
    end
  end

  logic rpin_n_s;
  logic nmi_s;
  assign rpin_n_s = pin_s2_r[0];
  assign nmi_s   = pin_s2_r[1];

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  pdm_byte_t sysctl_r;
  pdm_byte_t sysctl_nxt;
  pdm_byte_t mstop_r;
  pdm_byte_t mstop_nxt;

  // Selected NMI edge; 0 picks falling, 1 picks rising
  logic nmi_edge;
  always_comb
  begin
    if (sysctl_r[`PDM_EDGE_SEL_BIT])
      nmi_edge = nmi_s & ~nmi_d_r;
    else
      nmi_edge = ~nmi_s & nmi_d_r;
  end

  // ----------------------------------------------------------------
  // Operating state
  // ----------------------------------------------------------------
  pdm_state_t st_r;
  pdm_state_t st_nxt;
  logic [2:0] cnt_r;
  logic [2:0] cnt_nxt;
  logic [2:0] mode_r;
  logic [2:0] mode_nxt;

  always_comb
  begin
    st_nxt   = st_r;
    cnt_nxt  = cnt_r;
    mode_nxt = mode_r;
    unique case (st_r)
      PDM_RESET:
      begin
        // Mode is caught while reset holds; pins assumed stable
        mode_nxt = pin_s2_r[4:2];
        cnt_nxt  = 3'h0;
        if (rpin_n_s)
          st_nxt = PDM_RSTEXC;
      end
      PDM_RSTEXC:
      begin
        cnt_nxt = cnt_r + 3'h1;
        if (cnt_r == RSTEXC_LAST)
          st_nxt = PDM_RUN;
      end
      PDM_RUN:
      begin
        if (i_sleep_req)
        begin
          if (sysctl_r[`PDM_SOFT_STANDBY_BIT])
            st_nxt = PDM_SWSTBY;
          else
            st_nxt = PDM_SLEEP;
        end
      end
      PDM_SLEEP:
      begin
        if (i_irq | nmi_edge)
          st_nxt = PDM_RUN;
      end
      PDM_SWSTBY:
      begin
        if (nmi_edge)
          st_nxt = PDM_RUN;
      end
    endcase
    // Reset pin low overrides every state
    if (!rpin_n_s)
      st_nxt = PDM_RESET;
  end

  always_ff @(posedge i_core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      st_r   <= PDM_RESET;
      cnt_r  <= 3'h0;
      mode_r <= 3'h0;
    end
    else
    begin
      st_r   <= st_nxt;
      cnt_r  <= cnt_nxt;
      mode_r <= mode_nxt;
    end
  end

  // ----------------------------------------------------------------
  // AHB-Lite slave
  // ----------------------------------------------------------------
  logic      aph_wr_r;
  logic      aph_wr_nxt;
  logic [7:0] aph_ofs_r;
  logic [7:0] aph_ofs_nxt;
  logic [31:0] rd_r;
  logic [31:0] rd_nxt;
  logic      take;
  pdm_byte_t status;

  assign take = i_hsel & i_htrans[1] & i_hready;
  assign status = {osc_r, hws_r, 3'h0, 3'(st_r)};

  // Write in data phase; read data uses next values to stay coherent
  always_comb
  begin
    sysctl_nxt  = sysctl_r;
    mstop_nxt   = mstop_r;
    aph_wr_nxt  = take & i_hwrite;
    aph_ofs_nxt = take ? i_haddr[7:0] : aph_ofs_r;
    rd_nxt      = rd_r;
    if (aph_wr_r && aph_ofs_r == `PDM_SYSCTL_OFS)
      sysctl_nxt = i_hwdata[7:0];
    if (aph_wr_r && aph_ofs_r == `PDM_MSTOP_OFS)
      mstop_nxt = i_hwdata[7:0];
    if (take && !i_hwrite)
    begin
      unique case (i_haddr[7:0])
        `PDM_SYSCTL_OFS: rd_nxt = {24'h000000, sysctl_nxt};
        `PDM_MSTOP_OFS:  rd_nxt = {24'h000000, mstop_nxt};
        `PDM_STATUS_OFS: rd_nxt = {24'h000000, status};
        default:         rd_nxt = 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge i_core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sysctl_r  <= `PDM_SYSCTL_RST;
      mstop_r   <= `PDM_MSTOP_RST;
      aph_wr_r  <= 1'b0;
      aph_ofs_r <= 8'h00;
      rd_r      <= 32'h00000000;
    end
    else
    begin
      sysctl_r  <= sysctl_nxt;
      mstop_r   <= mstop_nxt;
      aph_wr_r  <= aph_wr_nxt;
      aph_ofs_r <= aph_ofs_nxt;
      rd_r      <= rd_nxt;
    end
  end

  // Zero wait states, always OKAY
  assign o_hreadyout = 1'b1;
  assign o_hresp     = 1'b0;
  assign o_hrdata    = rd_r;

  // ----------------------------------------------------------------
  // Power outputs
  // ----------------------------------------------------------------
  logic run_r;
  logic hold_r;
  logic ckoe_r;
  logic ckhi_r;
  logic nmiev_r;

  // Run, hold, clock and NMI outputs registered against decode glitches; o_reset_exc is decoded from st_r
  always_ff @(posedge i_core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      run_r   <= 1'b0;
      hold_r  <= 1'b0;
      ckoe_r  <= 1'b0; // floats in hardware standby
      ckhi_r  <= 1'b0;
      nmiev_r <= 1'b0;
    end
    else
    begin
      run_r   <= (st_nxt == PDM_RUN);
      hold_r  <= (st_nxt == PDM_SWSTBY);
      ckoe_r  <= ~mstop_nxt[`PDM_CLKOUT_DIS_BIT];
      ckhi_r  <= (st_nxt == PDM_SWSTBY);
      nmiev_r <= nmi_edge;
    end
  end

  assign o_state       = st_r;
  assign o_hw_standby  = hws_r;
  assign o_osc_enable  = osc_r;
  assign o_cpu_halt    = ~run_r;
  assign o_periph_halt = hold_r | hws_r;
  assign o_reset_exc   = (st_r == PDM_RSTEXC);
  assign o_nmi_event   = nmiev_r;
  assign o_port_hold   = hold_r;
  assign o_port_hiz    = hws_r;
  assign o_ram_enable  = sysctl_r[`PDM_RAM_EN_BIT];
  assign o_mode        = mode_r;
  assign o_clkout_oe   = ckoe_r & ~hws_r;
  assign o_clkout_high = ckhi_r;

  // ----------------------------------------------------------------
  // Module stop gates
  // ----------------------------------------------------------------
  // Lane order: 0 timer, 1 serial zero, 2 serial one, 3 converter
  logic [3:0] stop_bits;
  assign stop_bits = {mstop_r[`PDM_MST_ADC_BIT],
                      mstop_r[`PDM_MST_SC1_BIT],
                      mstop_r[`PDM_MST_SC0_BIT],
                      mstop_r[`PDM_MST_TMR_BIT]};

  // Stop bit updates at the end of the write, so halt starts next cycle
  assign o_mod_halt = stop_bits | {4{hws_r}};

  for (genvar m = 0; m < 4; m++)
  begin : g_gate
    pdm_gate_if gif ();

    assign gif.stop   = stop_bits[m];
    assign gif.rd_raw = i_mod_rdata[m*8 +: 8];
    assign gif.wr_req = i_mod_wr[m];
    assign o_mod_rdata[m*8 +: 8] = gif.rd_out;
    assign o_mod_wr[m]       = gif.wr_out;
    assign o_mod_rst_n[m]    = gif.mod_rst_n;
    assign o_mod_pin_func[m] = gif.pin_func;

    pdm_mod_gate u_gate
    (
      .i_core_clk (i_core_clk),
      .i_rst_n    (rst_n),
      .g          (gif.gate)
    );
  end
endmodule

// [verif/pdm_ext_ctrl.sv]
// External controller model driving the standby, reset and mode pins.
// Assumes the bench pulses i_go for one cycle to request a standby.
`timescale 1ns/1ps
module pdm_ext_ctrl
#(
  parameter int SETTLE_CYC = 16
)
(
  input  wire logic       i_core_clk,
  input  wire logic       i_go,
  input  wire logic [2:0] i_mode,
  output logic            o_standby_n,
  output logic            o_reset_n,
  output logic [2:0]      o_mode
);
  // Mode pins never move, standby or not
  assign o_mode = i_mode;

  // Power-on reset, then one standby cycle per request
  initial
  begin
    o_standby_n = 1'b1;
    o_reset_n   = 1'b0;
    repeat (20) @(posedge i_core_clk);
    o_reset_n <= 1'b1;
    forever
    begin
      @(posedge i_core_clk);
      if (i_go)
      begin
        o_reset_n <= 1'b0;
        repeat (4) @(posedge i_core_clk);
        o_standby_n <= 1'b0;
        repeat (10) @(posedge i_core_clk);
        o_standby_n <= 1'b1;
        // Reset stays low while the oscillator settles
        repeat (SETTLE_CYC) @(posedge i_core_clk);
        o_reset_n <= 1'b1;
      end
    end
  end
endmodule

// [verif/pdm_top_sva.sv]
// Port checker for the power-down controller top module.
// Assumes it is bound to pdm_top; sees only the top's ports.
`timescale 1ns/1ps
module pdm_top_sva
(
  input wire logic                i_core_clk,
  input wire logic                i_arst_n,
  input wire logic                i_standby_n_pin,
  input wire logic                i_sleep_req,
  input wire pdm_pkg::pdm_state_t o_state,
  input wire logic                o_hw_standby,
  input wire logic                o_osc_enable,
  input wire logic                o_cpu_halt,
  input wire logic                o_reset_exc,
  input wire logic                o_nmi_event,
  input wire logic                o_port_hold,
  input wire logic                o_port_hiz,
  input wire logic                o_clkout_oe,
  input wire logic                o_clkout_high,
  input wire logic [31:0]         o_mod_rdata,
  input wire logic [3:0]          o_mod_wr,
  input wire logic [3:0]          o_mod_rst_n,
  input wire logic [3:0]          o_mod_halt,
  input wire logic [3:0]          o_mod_pin_func
);
  import pdm_pkg::*;
  // --------------------------------------------------------------
  // Power states
  // --------------------------------------------------------------
  // Only the board reset disables: standby low must still be seen
  default clocking cb @(posedge i_core_clk);
  endclocking
  default disable iff (!i_arst_n);

  chk_hws_force: assert property (
    !i_standby_n_pin |-> o_hw_standby && o_port_hiz && !o_clkout_oe)
    else $error("standby pin low but outputs not in hw standby");
  chk_osc_start: assert property (
    $rose(i_standby_n_pin) |=> o_osc_enable)
    else $error("oscillator not restarted after standby rise");
  chk_sleep_entry: assert property (
    o_state == PDM_RUN && i_sleep_req |=> o_cpu_halt &&
    (o_state == PDM_SLEEP || o_state == PDM_SWSTBY))
    else $error("sleep request in run not taken");
  chk_swstby_pins: assert property (
    o_state == PDM_SWSTBY |-> o_port_hold && o_clkout_high)
    else $error("ports or clock pin not held in software standby");
  chk_nmi_exit: assert property (
    o_state == PDM_SWSTBY ##1 o_state == PDM_RUN |-> o_nmi_event)
    else $error("left software standby without an interrupt edge");
  chk_rstexc_len: assert property (
    $rose(o_reset_exc) |-> o_reset_exc [*8] ##1 o_state == PDM_RUN)
    else $error("reset exception length or exit wrong");
  // --------------------------------------------------------------
  // Module stop lanes
  // --------------------------------------------------------------
  for (genvar i = 0; i < 4; i++)
  begin : g_lane
    chk_stop_read: assert property (
      !o_hw_standby && o_mod_halt[i] |->
      o_mod_rdata[8*i +: 8] == 8'hFF && !o_mod_wr[i])
      else $error("stopped module not isolated");
    chk_stop_init: assert property (
      !o_hw_standby && $rose(o_mod_halt[i]) |=>
      !o_mod_rst_n[i] ##[0:1] !o_mod_pin_func[i])
      else $error("stopped module not reset or pins kept");
    chk_stop_clear: assert property (
      !$past(o_hw_standby) && $fell(o_mod_halt[i]) |=> o_mod_rst_n[i])
      else $error("cleared module still held in reset");
  end
endmodule

bind pdm_top pdm_top_sva u_sva
(
  .i_core_clk, .i_arst_n, .i_standby_n_pin, .i_sleep_req, .o_state,
  .o_hw_standby, .o_osc_enable, .o_cpu_halt, .o_reset_exc,
  .o_nmi_event, .o_port_hold, .o_port_hiz, .o_clkout_oe,
  .o_clkout_high, .o_mod_rdata, .o_mod_wr, .o_mod_rst_n, .o_mod_halt,
  .o_mod_pin_func
);

// [verif/tb.sv]
// Self-checking bench for the power-down controller.
// Assumes the design, package, checker and pin model are compiled.
`timescale 1ns/1ps
module tb;
  import pdm_pkg::*;
  localparam logic [7:0] LB [4] = '{8'h20, 8'h10, 8'h08, 8'h01};
  logic i_core_clk, i_arst_n, i_nmi_pin, i_sleep_req, i_irq, i_hsel;
  logic i_hwrite, go, rd_ph, i_standby_n_pin, i_reset_n_pin;
  logic [31:0] i_haddr, i_hwdata, i_mod_rdata, rnd, exp, ev;
  logic [1:0] i_htrans;
  logic [3:0] i_mod_wr, o_mod_wr, o_mod_rst_n, o_mod_halt, o_mod_pin_func;
  logic [2:0] i_mode_select_pins, o_mode, md;
  logic o_hreadyout, o_hresp, o_hw_standby, o_osc_enable, o_cpu_halt;
  logic o_periph_halt, o_port_hold, o_port_hiz, o_ram_enable;
  logic o_clkout_oe, o_clkout_high;
  logic [31:0] o_hrdata, o_mod_rdata;
  pdm_state_t o_state;
  logic [31:0] q [$];
  int error_cnt = 0;
  int n_tests = 0;

  pdm_top DUT
  (
    .i_core_clk, .i_arst_n, .i_standby_n_pin, .i_reset_n_pin, .i_nmi_pin,
    .i_mode_select_pins, .i_sleep_req, .i_irq, .i_mod_rdata, .i_mod_wr,
    .i_hsel, .i_haddr, .i_htrans, .i_hwrite, .i_hsize(3'h2), .i_hwdata,
    .i_hready(o_hreadyout), .o_hreadyout, .o_hresp, .o_hrdata, .o_state,
    .o_hw_standby, .o_osc_enable, .o_cpu_halt, .o_periph_halt,
    .o_reset_exc(), .o_nmi_event(), .o_port_hold, .o_port_hiz,
    .o_ram_enable, .o_mode, .o_clkout_oe, .o_clkout_high, .o_mod_rdata,
    .o_mod_wr, .o_mod_rst_n, .o_mod_halt, .o_mod_pin_func
  );
  pdm_ext_ctrl u_ext
  (
    .i_core_clk, .i_go(go), .i_mode(md), .o_standby_n(i_standby_n_pin),
    .o_reset_n(i_reset_n_pin), .o_mode(i_mode_select_pins)
  );
  // --------------------------------------------------------------
  // Helpers
  // --------------------------------------------------------------
  initial
  begin
    i_core_clk = 1'b0;
    forever #2.5 i_core_clk = ~i_core_clk;
  end
  function automatic logic [31:0] lfsr(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction
  task finish_test();
    if (error_cnt == 0 && n_tests > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  // Automatic: the read monitor and the main sequence may call it together
  task automatic cmp(input logic [31:0] g, input logic [31:0] e);
    n_tests++;
    if (g !== e)
    begin
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
      error_cnt++;
    end
  endtask
  task hung();
    $display("wrong value at %0t: wait ran out", $time);
    error_cnt++;
    finish_test();
  endtask
  // Wait for ready under a bound; the slave never stalls in practice
  task rdy_edge();
    int k;
    k = 0;
    do
    begin
      @(posedge i_core_clk);
      k++;
    end
    while (o_hreadyout !== 1'b1 && k < 64);
    if (k >= 64)
      hung();
  endtask
  task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge i_core_clk);
    i_haddr  <= {24'h0, a};
    i_htrans <= 2'h2;
    i_hwrite <= w;
    i_hsel   <= 1'b1;
    rdy_edge();
    i_htrans <= 2'h0;
    i_hsel   <= 1'b0;
    i_hwdata <= d;
    rd_ph    <= !w;
    rdy_edge();
    rd_ph    <= 1'b0;
  endtask
  task rd(input logic [7:0] a, input logic [31:0] e);
    q.push_back(e);
    bus(1'b0, a, 32'h0);
  endtask
  task wait_st(input pdm_state_t s);
    int k;
    k = 0;
    while (o_state !== s && k < 200)
    begin
      @(posedge i_core_clk);
      k++;
    end
    if (k >= 200)
      hung();
  endtask
  task pulse_sleep();
    @(posedge i_core_clk);
    i_sleep_req <= 1'b1;
    @(posedge i_core_clk);
    i_sleep_req <= 1'b0;
    @(negedge i_core_clk);
  endtask
  // Read data monitor: oldest note against the data phase result
  always @(posedge i_core_clk)
    if (rd_ph && o_hreadyout === 1'b1)
    begin
      ev = q.pop_front();
      cmp(o_hrdata, ev);
    end
  // --------------------------------------------------------------
  // Main sequence
  // --------------------------------------------------------------
  initial
  begin
    {i_arst_n, i_nmi_pin, i_sleep_req, i_irq, i_hsel, i_hwrite} = '0;
    {go, rd_ph, i_htrans, i_mod_wr} = '0;
    {i_haddr, i_hwdata, i_mod_rdata} = '0;
    rnd = lfsr(32'h40);
    md = rnd[8:6];
    repeat (12) @(posedge i_core_clk);
    i_arst_n <= 1'b1;
    wait_st(PDM_RUN);
    rd(8'h00, 32'h01);
    rd(8'h04, 32'h00);
    rd(8'h08, 32'h82);
    rd(8'h0C, 32'h00);
    cmp(o_mode, md);
    cmp(o_hresp, 1'b0);
    // Stop each module in turn over fresh random module data
    for (int i = 0; i < 4; i++)
    begin
      rnd = lfsr(rnd);
      bus(1'b1, 8'h04, {24'h0, LB[i]});
      @(posedge i_core_clk);
      i_mod_rdata <= rnd;
      i_mod_wr    <= 4'hF;
      @(negedge i_core_clk);
      exp = rnd;
      exp[8*i +: 8] = 8'hFF;
      cmp(o_mod_halt, 4'h1 << i);
      cmp(o_mod_rdata, exp);
      cmp(o_mod_wr, 4'hF & ~(4'h1 << i));
      cmp(o_mod_rst_n, 4'hF & ~(4'h1 << i));
      cmp(o_mod_pin_func[i], 1'b0);
      rd(8'h04, {24'h0, LB[i]});
      bus(1'b1, 8'h04, 32'h0);
      @(posedge i_core_clk);
      @(negedge i_core_clk);
      cmp(o_mod_rst_n, 4'hF);
      cmp(o_mod_rdata, rnd);
    end
    bus(1'b1, 8'h04, 32'h80);
    @(posedge i_core_clk);
    @(negedge i_core_clk);
    cmp(o_clkout_oe, 1'b0);
    bus(1'b1, 8'h04, 32'h00);
    @(posedge i_core_clk);
    @(negedge i_core_clk);
    cmp(o_clkout_oe, 1'b1);
    // Plain sleep keeps the clock pin running
    bus(1'b1, 8'h00, 32'h01);
    pulse_sleep();
    cmp(o_state, PDM_SLEEP);
    cmp(o_clkout_oe, 1'b1);
    @(posedge i_core_clk);
    i_irq <= 1'b1;
    wait_st(PDM_RUN);
    i_irq <= 1'b0;
    // Software standby with each edge; the other edge must not wake
    for (int eg = 0; eg < 2; eg++)
    begin
      @(posedge i_core_clk);
      i_nmi_pin <= eg[0];
      bus(1'b1, 8'h00, 32'h81 | (eg << 2));
      repeat (4) @(posedge i_core_clk);
      pulse_sleep();
      cmp(o_state, PDM_SWSTBY);
      cmp(o_port_hold, 1'b1);
      cmp(o_clkout_high, 1'b1);
      @(posedge i_core_clk);
      i_nmi_pin <= !eg[0];
      repeat (6) @(posedge i_core_clk);
      @(negedge i_core_clk);
      cmp(o_state, PDM_SWSTBY);
      @(posedge i_core_clk);
      i_nmi_pin <= eg[0];
      wait_st(PDM_RUN);
    end
    // Hardware standby must wipe the registers set here
    bus(1'b1, 8'h00, 32'h80);
    bus(1'b1, 8'h04, 32'h21);
    cmp(o_ram_enable, 1'b0);
    @(posedge i_core_clk);
    go <= 1'b1;
    @(posedge i_core_clk);
    go <= 1'b0;
    wait_st(PDM_RESET);
    repeat (6) @(posedge i_core_clk);
    @(negedge i_core_clk);
    cmp(o_port_hiz, 1'b1);
    cmp(o_hw_standby, 1'b1);
    cmp({o_cpu_halt, o_periph_halt, o_mod_rst_n}, 6'h30);
    cmp({o_clkout_oe, o_osc_enable}, 2'h0);
    wait_st(PDM_RUN);
    rd(8'h00, 32'h01);
    rd(8'h04, 32'h00);
    cmp(o_ram_enable, 1'b1);
    @(posedge i_core_clk);
    finish_test();
  end
endmodule
